// [inc/pgb_pkg.sv]
// pgb_pkg: constants, types and register map of the second power-good aggregator
package pgb_pkg;

    // clock and rise-delay timing
    localparam int unsigned     PGB_CLK_HZ          = 125_000_000;  // system clock rate
    localparam int unsigned     PGB_RISE_DELAY_MS   = 11;           // rise hold-off in ms
    // least time, so rounded up to whole cycles
    localparam longint unsigned PGB_RISE_DELAY_CYC_L =
        (longint'(PGB_RISE_DELAY_MS) * longint'(PGB_CLK_HZ) + 64'd999) / 64'd1000;
    localparam int              PGB_RISE_DELAY_CYC  = int'(PGB_RISE_DELAY_CYC_L);
    localparam int              PGB_CNT_W           = 21;           // holds 1,375,000

    // register offsets on the plain register port
    localparam logic [7:0]      PGB_OFF_SELECT      = 8'h1A;        // source select
    localparam logic [7:0]      PGB_OFF_FAULT       = 8'h1B;        // fault flags, w1c
    localparam logic [7:0]      PGB_OFF_IRQ_STATUS  = 8'h30;        // sticky events, ro
    localparam logic [7:0]      PGB_OFF_IRQ_ENABLE  = 8'h31;        // event enables, rw
    localparam logic [7:0]      PGB_OFF_IRQ_CLEAR   = 8'h32;        // event clear, wo

    // field positions, shared by select, fault and interrupt registers
    localparam int              PGB_BIT_RISE_DLY    = 7;
    localparam int              PGB_BIT_THERMAL     = 6;
    localparam int              PGB_BIT_ANALOG      = 5;
    localparam int              PGB_BIT_MON_B       = 4;
    localparam int              PGB_BIT_MON_A       = 3;
    localparam int              PGB_BIT_STEP_UP     = 2;
    localparam int              PGB_BIT_STEP_DN_B   = 1;
    localparam int              PGB_BIT_STEP_DN_A   = 0;
    localparam int              PGB_NUM_SRC         = 7;

    // values after reset
    localparam logic [7:0]      PGB_SELECT_RST      = 8'h00;
    localparam logic [6:0]      PGB_FLAGS_RST       = 7'h00;
    localparam logic [7:0]      PGB_RDATA_RST       = 8'h00;

    // output sequencing states
    typedef enum logic [1:0] {
        PGB_ST_LOW  = 2'b00,    // output inactive
        PGB_ST_WAIT = 2'b01,    // all good, rise delay running
        PGB_ST_GOOD = 2'b10     // output active
    } pgb_state_t;

    // one register-port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr_stb;
        logic       rd_stb;
    } pgb_bus_req_t;

    // monitored sources, packed in field order 6..0
    typedef struct packed {
        logic thermal_warning;          // high = warning active
        logic analog_supply_input;      // high = above threshold
        logic ext_voltage_monitor_b;
        logic ext_voltage_monitor_a;
        logic step_up_rail;
        logic step_down_rail_b;
        logic step_down_rail_a;
    } pgb_src_t;

endpackage : pgb_pkg

// [core/pgb_rise_timer.sv]
// pgb_rise_timer: counts the rise hold-off while the run level is high
`timescale 1ns/1ps
module pgb_rise_timer #(
    parameter int CNT_W = pgb_pkg::PGB_CNT_W,
    parameter int LIMIT = pgb_pkg::PGB_RISE_DELAY_CYC
) (
    input  logic clk_sys,
    input  logic sys_rst,
    input  logic run,
    output logic done
);

    logic [CNT_W-1:0] count_reg;   // cycles spent with run high
    logic [CNT_W-1:0] count_next;

    // done in the cycle that completes LIMIT cycles of run
    assign done = run && (count_reg == CNT_W'(LIMIT - 1));

    // restart from zero whenever run drops, so each wait is full length
    assign count_next = !run ? '0 : (done ? count_reg : count_reg + CNT_W'(1));

    // counter register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule : pgb_rise_timer

// [core/pgb_aggregator.sv]
// pgb_aggregator: second power-good output, source select, fault flags, interrupt
`timescale 1ns/1ps
// What this block does
// - select bit 7 delays output rise 11 ms
// - select bit 6 lets thermal warning drop output
// - select bit 5 includes analog supply input
// - select bit 4 includes external monitor b
// - select bit 3 includes external monitor a
// - select bit 2 includes step-up rail
// - select bit 1 includes step-down rail b
// - select bit 0 includes step-down rail a
// - select bits 6..0 load defaults from configuration memory
// - thermal fault flag bit 6, w1c when clear
// - analog supply fault flag bit 5, w1c when valid
// - monitor b fault flag bit 4, w1c when valid
// - monitor a fault flag bit 3, w1c when valid
// - step-up fault flag bit 2, w1c when valid
// - step-down b fault flag bit 1, w1c when valid
// - step-down a fault flag bit 0, w1c when valid
module pgb_aggregator #(
    parameter int RISE_DELAY_CYC = pgb_pkg::PGB_RISE_DELAY_CYC,  // rise hold-off in cycles
    parameter int CNT_W          = pgb_pkg::PGB_CNT_W            // hold-off counter width
) (
    input  logic                 clk_sys,           // 125 MHz system clock
    input  logic                 sys_rst,           // synchronous reset, active high
    input  pgb_pkg::pgb_bus_req_t bus_req,          // register port request
    output logic [7:0]           rd_data,           // read data, cycle after rd_stb
    input  pgb_pkg::pgb_src_t    src,               // monitored source levels
    input  logic [6:0]           otp_select,        // configuration-memory select defaults
    output logic                 power_good_out_b,  // second power-good, high = good
    output logic                 irq                // level interrupt
);

    // ------------------------------------------------------------------
    // register-port decode
    // ------------------------------------------------------------------

    // address match used by the write decode; the read path decodes the address in its own case
    function automatic logic pgb_hit(input logic [7:0] addr, input logic [7:0] off);
        pgb_hit = (addr == off);
    endfunction : pgb_hit

    wire wr_select  = bus_req.wr_stb && pgb_hit(bus_req.addr, pgb_pkg::PGB_OFF_SELECT);
    wire wr_fault   = bus_req.wr_stb && pgb_hit(bus_req.addr, pgb_pkg::PGB_OFF_FAULT);
    wire wr_irq_en  = bus_req.wr_stb && pgb_hit(bus_req.addr, pgb_pkg::PGB_OFF_IRQ_ENABLE);
    wire wr_irq_clr = bus_req.wr_stb && pgb_hit(bus_req.addr, pgb_pkg::PGB_OFF_IRQ_CLEAR);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------

    logic [7:0]             select_reg;       // rise-delay enable plus source selects
    logic [7:0]             select_next;
    logic                   otp_loaded_reg;   // defaults taken after reset release
    logic [6:0]             fault_reg;        // sticky fault flags
    logic [6:0]             fault_next;
    logic [6:0]             irq_status_reg;   // sticky interrupt events
    logic [6:0]             irq_status_next;
    logic [6:0]             irq_enable_reg;   // interrupt enables
    logic [6:0]             irq_enable_next;
    logic [7:0]             rd_data_reg;      // registered read answer
    logic [7:0]             rd_data_next;
    pgb_pkg::pgb_state_t    state_reg;        // output sequencing
    pgb_pkg::pgb_state_t    state_next;

    // ------------------------------------------------------------------
    // source qualification
    // ------------------------------------------------------------------

    // ok[i] is high while source i reports valid, whatever the select
    wire [6:0] src_ok;
    assign src_ok[pgb_pkg::PGB_BIT_THERMAL]   = ~src.thermal_warning;
    assign src_ok[pgb_pkg::PGB_BIT_ANALOG]    = src.analog_supply_input;
    assign src_ok[pgb_pkg::PGB_BIT_MON_B]     = src.ext_voltage_monitor_b;
    assign src_ok[pgb_pkg::PGB_BIT_MON_A]     = src.ext_voltage_monitor_a;
    assign src_ok[pgb_pkg::PGB_BIT_STEP_UP]   = src.step_up_rail;
    assign src_ok[pgb_pkg::PGB_BIT_STEP_DN_B] = src.step_down_rail_b;
    assign src_ok[pgb_pkg::PGB_BIT_STEP_DN_A] = src.step_down_rail_a;

    // a masked source always passes, a selected one passes only while valid
    wire [6:0] src_pass;
    assign src_pass[6] = ~select_reg[6] | src_ok[6];
    assign src_pass[5] = ~select_reg[5] | src_ok[5];
    assign src_pass[4] = ~select_reg[4] | src_ok[4];
    assign src_pass[3] = ~select_reg[3] | src_ok[3];
    assign src_pass[2] = ~select_reg[2] | src_ok[2];
    assign src_pass[1] = ~select_reg[1] | src_ok[1];
    assign src_pass[0] = ~select_reg[0] | src_ok[0];

    wire all_ok    = &src_pass;
    wire delay_en  = select_reg[pgb_pkg::PGB_BIT_RISE_DLY];
    wire [6:0] src_bad = ~src_pass;                      // selected and invalid

    // ------------------------------------------------------------------
    // rise hold-off timer
    // ------------------------------------------------------------------

    wire timer_done;
    pgb_rise_timer #(
        .CNT_W (CNT_W),
        .LIMIT (RISE_DELAY_CYC)
    ) u_rise_timer (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .run     (state_reg == pgb_pkg::PGB_ST_WAIT),
        .done    (timer_done)
    );

    // ------------------------------------------------------------------
    // output sequencing
    // ------------------------------------------------------------------

    // any selected invalid source drops the output on the next edge
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pgb_pkg::PGB_ST_LOW: begin
                if (all_ok) begin
                    // with the delay on, stay low until the timer expires
                    state_next = delay_en ? pgb_pkg::PGB_ST_WAIT : pgb_pkg::PGB_ST_GOOD;
                end
            end
            pgb_pkg::PGB_ST_WAIT: begin
                if (!all_ok) begin
                    state_next = pgb_pkg::PGB_ST_LOW;
                end else if (timer_done) begin
                    state_next = pgb_pkg::PGB_ST_GOOD;
                end
            end
            pgb_pkg::PGB_ST_GOOD: begin
                if (!all_ok) begin
                    state_next = pgb_pkg::PGB_ST_LOW;
                end
            end
            default: begin
                state_next = pgb_pkg::PGB_ST_LOW;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // source select register
    // ------------------------------------------------------------------

    // first edge after release takes the configuration defaults; the delay
    // bit has no stored default and keeps its reset value
    assign select_next = !otp_loaded_reg ? {select_reg[7], otp_select}
                       : wr_select       ? bus_req.wdata
                       :                   select_reg;

    // ------------------------------------------------------------------
    // fault flags
    // ------------------------------------------------------------------

    // write one clears a flag only while its source is valid again; a clear
    // and a set cannot meet since the set needs the source invalid
    wire [6:0] fault_clr = wr_fault ? (bus_req.wdata[6:0] & src_ok) : 7'h00;
    genvar gi;
    generate
        for (gi = 0; gi < pgb_pkg::PGB_NUM_SRC; gi++) begin : g_fault
            // set wins over clear, flag held otherwise
            assign fault_next[gi] = src_bad[gi] | (fault_reg[gi] & ~fault_clr[gi]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------

    // an event is a fault flag being newly set
    wire [6:0] irq_event = src_bad & ~fault_reg;
    wire [6:0] irq_clr   = wr_irq_clr ? bus_req.wdata[6:0] : 7'h00;
    assign irq_status_next = irq_event | (irq_status_reg & ~irq_clr);
    assign irq_enable_next = wr_irq_en ? bus_req.wdata[6:0] : irq_enable_reg;
    assign irq             = |(irq_status_reg & irq_enable_reg);

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    // unmapped and write-only offsets read zero; reserved bit 7 reads zero
    always_comb begin
        rd_data_next = pgb_pkg::PGB_RDATA_RST;
        if (bus_req.rd_stb) begin
            case (bus_req.addr)
                pgb_pkg::PGB_OFF_SELECT:     rd_data_next = select_reg;
                pgb_pkg::PGB_OFF_FAULT:      rd_data_next = {1'b0, fault_reg};
                pgb_pkg::PGB_OFF_IRQ_STATUS: rd_data_next = {1'b0, irq_status_reg};
                pgb_pkg::PGB_OFF_IRQ_ENABLE: rd_data_next = {1'b0, irq_enable_reg};
                default:                     rd_data_next = pgb_pkg::PGB_RDATA_RST;
            endcase
        end
    end

    assign rd_data          = rd_data_reg;
    assign power_good_out_b = (state_reg == pgb_pkg::PGB_ST_GOOD);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------

    // control and sequencing state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            select_reg     <= pgb_pkg::PGB_SELECT_RST;
            otp_loaded_reg <= 1'b0;
            state_reg      <= pgb_pkg::PGB_ST_LOW;
        end else begin
            select_reg     <= select_next;
            otp_loaded_reg <= 1'b1;
            state_reg      <= state_next;
        end
    end

    // flags, interrupt and read answer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fault_reg      <= pgb_pkg::PGB_FLAGS_RST;
            irq_status_reg <= pgb_pkg::PGB_FLAGS_RST;
            irq_enable_reg <= pgb_pkg::PGB_FLAGS_RST;
            rd_data_reg    <= pgb_pkg::PGB_RDATA_RST;
        end else begin
            fault_reg      <= fault_next;
            irq_status_reg <= irq_status_next;
            irq_enable_reg <= irq_enable_next;
            rd_data_reg    <= rd_data_next;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // any selected invalid source forces the output low next cycle
    a_drop_on_bad: assert property (
        !all_ok |=> !power_good_out_b
    ) else $error("output stayed active with a selected source invalid");

    // without the delay the output rises one cycle after all sources are good
    a_fast_rise: assert property (
        (state_reg == pgb_pkg::PGB_ST_LOW) && all_ok && !delay_en |=> power_good_out_b
    ) else $error("undelayed rise did not happen on the next edge");

    // with the delay the output stays low for the next two cycles
    a_delay_holds: assert property (
        (state_reg == pgb_pkg::PGB_ST_LOW) && all_ok && delay_en
        |=> !power_good_out_b [*2]
    ) else $error("delayed rise came too early");

    // the delayed rise follows the timer exactly
    a_delay_expiry: assert property (
        (state_reg == pgb_pkg::PGB_ST_WAIT) && all_ok && timer_done |=> power_good_out_b
    ) else $error("output did not rise when the hold-off expired");

    // configuration defaults land on the first edge after reset
    a_otp_default: assert property (
        !otp_loaded_reg |=> select_reg[6:0] == $past(otp_select)
    ) else $error("select defaults not loaded after reset");

    // reserved bit of the fault register reads zero
    a_reserved_zero: assert property (
        bus_req.rd_stb && (bus_req.addr == pgb_pkg::PGB_OFF_FAULT) |=> !rd_data[7]
    ) else $error("reserved fault bit read as one");

    // per-source flag behaviour
    generate
        for (gi = 0; gi < pgb_pkg::PGB_NUM_SRC; gi++) begin : g_chk
            // a selected invalid source sets its flag
            a_fault_sets: assert property (
                select_reg[gi] && !src_ok[gi] |=> fault_reg[gi]
            ) else $error("fault flag not set by a selected invalid source");

            // a clear while the source is still invalid is ignored
            a_clear_blocked: assert property (
                fault_reg[gi] && !src_ok[gi] |=> fault_reg[gi]
            ) else $error("fault flag lost while its source is invalid");

            // a write of one with the source valid clears the flag
            a_clear_works: assert property (
                wr_fault && bus_req.wdata[gi] && src_ok[gi] |=> !fault_reg[gi]
            ) else $error("fault flag not cleared by a valid write of one");

            // a deselected source never raises its flag
            a_masked_quiet: assert property (
                !select_reg[gi] && !fault_reg[gi] |=> !fault_reg[gi]
            ) else $error("deselected source raised its fault flag");
        end
    endgenerate

    // an enabled event raises the interrupt on the next edge; an enable
    // write in the same cycle may mask it, so that case is left out
    a_irq_raise: assert property (
        (|(irq_event & irq_enable_reg)) && !wr_irq_en |=> irq
    ) else $error("enabled event did not raise the interrupt");

    // with no status and no new event the interrupt stays low
    a_irq_quiet: assert property (
        (irq_status_reg == 7'h00) && (irq_event == 7'h00) |=> !irq
    ) else $error("interrupt raised without a status bit");

    // read data stands only in the cycle after a read strobe
    a_rd_idle_zero: assert property (
        !bus_req.rd_stb |=> rd_data == 8'h00
    ) else $error("read data not zero outside a read answer");

    // a select write lands on its edge once the defaults are in
    a_select_write: assert property (
        otp_loaded_reg && wr_select |=> select_reg == $past(bus_req.wdata)
    ) else $error("select write did not land");

    // an active output was earned by all selected sources on the edge before
    a_good_needs_ok: assert property (
        power_good_out_b |-> $past(all_ok)
    ) else $error("output active without all selected sources valid");

    // leaving the low state restarts the hold-off from zero
    a_timer_restart: assert property (
        (state_reg == pgb_pkg::PGB_ST_LOW) |=> !timer_done
    ) else $error("hold-off timer not restarted after a drop");

    // main scenarios
    c_delayed_rise: cover property (
        (state_reg == pgb_pkg::PGB_ST_WAIT) ##1 (state_reg == pgb_pkg::PGB_ST_GOOD)
    );
    c_fault_drop: cover property (
        power_good_out_b ##1 (!power_good_out_b && fault_reg != 7'h00)
    );
    c_fault_cleared: cover property (
        (fault_reg != 7'h00) ##1 (fault_reg == 7'h00)
    );
    c_irq_fires: cover property (
        $rose(irq)
    );
    c_masked_ignored: cover property (
        power_good_out_b && !select_reg[0] && !src_ok[0]
    );

endmodule : pgb_aggregator

// [verification/pgb_aggregator_bench.sv]
// pgb_aggregator_bench: self-checking bench for the second power-good aggregator
`timescale 1ns/1ps
module pgb_aggregator_bench;
    localparam int DLY = 20;                      // shortened rise hold-off, keeps the run short
    logic                  clk_sys    = 1'b0;     // 125 MHz system clock
    logic                  sys_rst    = 1'b1;     // synchronous reset, active high
    pgb_pkg::pgb_bus_req_t bus_req    = '0;       // register port request
    logic [7:0]            rd_data;               // read data from the block
    pgb_pkg::pgb_src_t     src        = pgb_pkg::pgb_src_t'(7'h3F); // all sources valid
    logic [6:0]            otp_select = 7'h00;    // configuration defaults
    logic                  power_good_out_b;      // second power-good output
    logic                  irq;                   // level interrupt
    logic [7:0]            exp_q[$];              // expected read data, oldest first
    logic                  rd_seen    = 1'b0;     // read strobe was taken last edge
    logic [31:0]           rnd;                   // random state
    logic [6:0]            sel;                   // chosen select bits
    logic [6:0]            b;                     // chosen bad sources
    logic [6:0]            ef;                    // modelled fault flags
    logic [6:0]            m;                     // source under test
    logic [6:0]            o;                     // deselected neighbour
    int                    error_cnt   = 0;       // mismatches
    int                    checks_done = 0;       // comparisons made
    int                    cyc         = 0;       // cycles since start

    // free-running clock, 8 ns period
    always #4 clk_sys = ~clk_sys;

    pgb_aggregator #(
        .RISE_DELAY_CYC (DLY),
        .CNT_W          (pgb_pkg::PGB_CNT_W)
    ) dut (
        .clk_sys          (clk_sys),
        .sys_rst          (sys_rst),
        .bus_req          (bus_req),
        .rd_data          (rd_data),
        .src              (src),
        .otp_select       (otp_select),
        .power_good_out_b (power_good_out_b),
        .irq              (irq)
    );

    // galois shift register, fixed seed gives a repeatable run
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr

    // verdict in one place
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // compare one read result
    task automatic check_rd(input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error rd_data expected %h seen %h", exp, got);
        end
    endtask : check_rd

    // compare one output pin level
    task automatic check_pin(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check_pin

    // one-cycle write strobe, released on the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr_stb: 1'b1, rd_stb: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask : wr

    // one-cycle read strobe; the watcher compares the data a cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr_stb: 1'b0, rd_stb: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask : rd

    // drive sources from a bad-source mask; thermal is bad when high
    task automatic drv(input logic [6:0] bad);
        @(posedge clk_sys);
        src <= pgb_pkg::pgb_src_t'(bad ^ 7'h3F);
    endtask : drv

    // let the sampling edge pass and its updates land
    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask : settle

    // watcher: read data stands only in the cycle after the strobe; hang guard
    always @(posedge clk_sys) begin
        if (rd_seen) begin
            check_rd(exp_q.pop_front(), rd_data);
        end
        rd_seen <= bus_req.rd_stb;
        cyc     <= cyc + 1;
        if (cyc > 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // main sequence
    initial begin
        rnd = lfsr(32'h677E8CE0);
        otp_select <= rnd[6:0];
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(8'h1A, {1'b0, otp_select});
        rd(8'h1B, 8'h00);
        $display("test reset_defaults done");
        wr(8'h1A, 8'hA5);
        rd(8'h1A, 8'hA5);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        rd(8'h32, 8'h00);
        wr(8'h1B, 8'hFF);
        rd(8'h1B, 8'h00);
        $display("test register_map done");
        // delayed rise, with an abort that must restart the hold-off
        wr(8'h1A, 8'h81);
        drv(7'h01);
        settle();
        check_pin("power_good_out_b", 1'b0, power_good_out_b);
        drv(7'h00);
        repeat (10) @(posedge clk_sys);
        drv(7'h01);
        drv(7'h00);
        repeat (DLY) @(posedge clk_sys);
        #1;
        check_pin("power_good_out_b", 1'b0, power_good_out_b);
        settle();
        check_pin("power_good_out_b", 1'b1, power_good_out_b);
        wr(8'h1A, 8'h01);
        drv(7'h01);
        drv(7'h00);
        settle();
        check_pin("power_good_out_b", 1'b1, power_good_out_b);
        wr(8'h1B, 8'h7F);
        wr(8'h32, 8'h7F);
        $display("test rise_delay done");
        // each source alone: drop, flag, refused and accepted clears, interrupt
        for (int i = 0; i < 7; i++) begin
            m = 7'h01 << i;
            o = 7'h01 << ((i + 1) % 7);
            wr(8'h31, {1'b0, (i == 3) ? (7'h7F & ~m) : 7'h7F});
            wr(8'h1A, {1'b0, m});
            drv(m | o);
            settle();
            check_pin("power_good_out_b", 1'b0, power_good_out_b);
            check_pin("irq", (i != 3), irq);
            rd(8'h1B, {1'b0, m});
            rd(8'h30, {1'b0, m});
            wr(8'h1B, {1'b0, m});
            rd(8'h1B, {1'b0, m});
            drv(o);
            settle();
            check_pin("power_good_out_b", 1'b1, power_good_out_b);
            rd(8'h1B, {1'b0, m});
            wr(8'h1B, 8'h00);
            rd(8'h1B, {1'b0, m});
            wr(8'h1B, {1'b0, m});
            rd(8'h1B, 8'h00);
            wr(8'h32, {1'b0, m});
            #1;
            check_pin("irq", 1'b0, irq);
            drv(7'h00);
        end
        $display("test per_source done");
        // random selections and source faults against a model of the flags
        wr(8'h31, 8'h7F);
        rd(8'h31, 8'h7F);
        ef = 7'h00;
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr(rnd);
            sel = rnd[6:0];
            drv(7'h00);
            wr(8'h1A, {1'b0, sel});
            for (int j = 0; j < 8; j++) begin
                rnd = lfsr(rnd);
                b = rnd[6:0];
                drv(b);
                settle();
                check_pin("power_good_out_b", (b & sel) == 7'h00, power_good_out_b);
                ef = ef | (b & sel);
            end
        end
        drv(7'h00);
        rd(8'h1B, {1'b0, ef});
        rd(8'h30, {1'b0, ef});
        settle();
        check_pin("irq", ef != 7'h00, irq);
        $display("test random_sources done");
        repeat (3) @(posedge clk_sys);
        tally_and_finish();
    end

endmodule : pgb_aggregator_bench
